// ---- core/fmc_host.sv ----
// Host-side controller driving the flash strobes, address and data pins
`timescale 1ns/100ps
module fmc_host
    import fmc_pkg::*;
#(
    parameter int WAKE_CYCLES = C_WAKE,
    parameter int PROT_CYCLES = C_PROT_PULSE
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire fmc_op_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic rsp_parity_ok,
    output logic rsp_protected,
    output logic busy,
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic addr_bit_nine_hv,
    output logic oe_hv,
    output logic reset_hv,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_i
);
    typedef enum logic [2:0] {
        ST_RST,
        ST_WAKE,
        ST_IDLE,
        ST_READ,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD
    } fmc_state_t;

    initial
    begin
        if (WAKE_CYCLES < 2 || WAKE_CYCLES >= (1 << TIMER_W))
            $error("fmc_host: WAKE_CYCLES out of range");
        if (PROT_CYCLES < 1 || PROT_CYCLES >= (1 << TIMER_W))
            $error("fmc_host: PROT_CYCLES out of range");
    end

    fmc_state_t state_ff;
    fmc_state_t nxt_state;
    fmc_op_t op_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] data_ff;
    logic unprot_ff;
    logic rsp_valid_ff;
    logic [DATA_W-1:0] rsp_data_ff;
    logic parity_ok_ff;
    logic prot_ff;
    logic tmr_load;
    logic [TIMER_W-1:0] tmr_value;
    logic tmr_done;
    logic [ADDR_W-1:0] shaped_addr;
    logic accept;
    logic hv_op;
    logic in_bus;
    logic in_write;
    logic read_done;
    logic write_done;
    logic boot_ff;

    fmc_timer #(.W(TIMER_W)) u_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    assign cmd_ready = (state_ff == ST_IDLE);
    assign accept = cmd_ready && cmd_valid;
    assign busy = !cmd_ready;

    // Force the address bits the device interprets in high voltage modes
    always_comb
    begin
        shaped_addr = cmd_addr;
        case (cmd_op)
            OP_ID_READ: shaped_addr[A_ONE_POS] = 1'b0;
            OP_PROT_VERIFY:
            begin
                shaped_addr[A_SIX_POS] = 1'b0;
                shaped_addr[A_ONE_POS] = 1'b1;
                shaped_addr[A_ZERO_POS] = 1'b0;
            end
            OP_PROTECT: shaped_addr[A_SIX_POS] = 1'b0;
            default: shaped_addr = cmd_addr;
        endcase
    end

    // Next state and phase timer loads
    always_comb
    begin
        nxt_state = state_ff;
        tmr_load = 1'b0;
        tmr_value = TIMER_W'(1);
        case (state_ff)
            ST_RST:
                if (boot_ff)
                begin
                    // Timer is cleared by srst, so the reset pulse is armed here
                    tmr_load = 1'b1;
                    tmr_value = TIMER_W'(C_RESET_LOW);
                end
                else if (tmr_done)
                begin
                    nxt_state = ST_WAKE;
                    tmr_load = 1'b1;
                    tmr_value = TIMER_W'(WAKE_CYCLES);
                end
            ST_WAKE:
                if (tmr_done)
                    nxt_state = ST_IDLE;
            ST_IDLE:
                if (accept)
                begin
                    case (cmd_op)
                        OP_READ, OP_ID_READ, OP_PROT_VERIFY:
                        begin
                            nxt_state = ST_READ;
                            tmr_load = 1'b1;
                            tmr_value = TIMER_W'(C_ACC);
                        end
                        OP_WRITE, OP_PROTECT:
                        begin
                            nxt_state = ST_WR_SETUP;
                            tmr_load = 1'b1;
                        end
                        OP_RESET:
                        begin
                            nxt_state = ST_RST;
                            tmr_load = 1'b1;
                            tmr_value = TIMER_W'(C_RESET_LOW);
                        end
                        default: nxt_state = ST_IDLE;
                    endcase
                end
            ST_READ:
                if (tmr_done)
                    nxt_state = ST_IDLE;
            ST_WR_SETUP:
                if (tmr_done)
                begin
                    nxt_state = ST_WR_PULSE;
                    tmr_load = 1'b1;
                    tmr_value = (op_ff == OP_PROTECT) ? TIMER_W'(PROT_CYCLES)
                                                      : TIMER_W'(C_WE_PULSE);
                end
            ST_WR_PULSE:
                if (tmr_done)
                begin
                    nxt_state = ST_WR_HOLD;
                    tmr_load = 1'b1;
                end
            ST_WR_HOLD:
                if (tmr_done)
                    nxt_state = ST_IDLE;
            default: nxt_state = ST_RST;
        endcase
    end

    assign read_done = (state_ff == ST_READ) && tmr_done;
    assign write_done = (state_ff == ST_WR_HOLD) && tmr_done;

    // Reset entry pulses the device reset so the first read is never stale
    always_ff @(posedge ref_clk)
    begin
        boot_ff <= srst;
        if (srst)
            state_ff <= ST_RST;
        else
            state_ff <= nxt_state;
    end

    // Address stays parked after a cycle; the device may sleep on it
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            op_ff <= OP_READ;
            addr_ff <= '0;
            data_ff <= '0;
        end
        else if (accept)
        begin
            op_ff <= cmd_op;
            addr_ff <= shaped_addr;
            data_ff <= cmd_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            unprot_ff <= 1'b0;
        else if (accept && cmd_op == OP_UNPROT_ON)
            unprot_ff <= 1'b1;
        else if (accept && cmd_op == OP_UNPROT_OFF)
            unprot_ff <= 1'b0;
    end

    // Sample the data pins at the end of the access window
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rsp_data_ff <= '0;
            parity_ok_ff <= 1'b0;
            prot_ff <= 1'b0;
        end
        else if (read_done)
        begin
            rsp_data_ff <= dq_i;
            parity_ok_ff <= ^dq_i[PARITY_POS:0];
            prot_ff <= dq_i[PROT_FLAG_POS];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rsp_valid_ff <= 1'b0;
        else
            rsp_valid_ff <= read_done || write_done ||
                (accept && (cmd_op == OP_UNPROT_ON || cmd_op == OP_UNPROT_OFF));
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign rsp_parity_ok = parity_ok_ff;
    assign rsp_protected = prot_ff;

    // Pin decode from registered state; idle keeps select high for standby
    assign in_write = (state_ff == ST_WR_SETUP) || (state_ff == ST_WR_PULSE) ||
                      (state_ff == ST_WR_HOLD);
    assign in_bus = in_write || (state_ff == ST_READ);
    assign hv_op = (op_ff == OP_ID_READ) || (op_ff == OP_PROT_VERIFY) ||
                   (op_ff == OP_PROTECT);
    assign flash_addr = addr_ff;
    assign flash_ce_n = !in_bus;
    assign flash_oe_n = (state_ff != ST_READ);
    assign flash_we_n = (state_ff != ST_WR_PULSE);
    assign flash_reset_n = (state_ff != ST_RST);
    assign addr_bit_nine_hv = in_bus && hv_op;
    assign oe_hv = in_write && (op_ff == OP_PROTECT);
    assign reset_hv = unprot_ff && flash_reset_n;
    assign dq_o = data_ff;
    assign dq_oe = in_write && (op_ff == OP_WRITE);

    AST_READ_STROBES: assert property (@(posedge ref_clk) disable iff (srst)
        read_done |-> (!flash_ce_n && !flash_oe_n && !flash_we_n == 1'b0)
                      [*1] ##0 $past(!flash_oe_n))
        else $error("read sampled without both strobes low");

    AST_RESET_FIRST: assert property (@(posedge ref_clk) disable iff (srst)
        $past(srst) |-> !flash_reset_n [*2])
        else $error("no device reset after controller reset");

    AST_ID_A1_LOW: assert property (@(posedge ref_clk) disable iff (srst)
        (addr_bit_nine_hv && op_ff == OP_ID_READ) |-> !flash_addr[A_ONE_POS])
        else $error("identifier read with address bit one high");

    AST_PROT_SETUP: assert property (@(posedge ref_clk) disable iff (srst)
        (!flash_we_n && addr_bit_nine_hv) |->
            (oe_hv && !flash_ce_n && !flash_addr[A_SIX_POS]))
        else $error("protect pulse without proper qualifiers");

    AST_PROT_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        (!flash_we_n && $past(!flash_we_n)) |-> $stable(flash_addr))
        else $error("address moved during write pulse");

    AST_WRITE_OE: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(flash_we_n) |-> $past(!flash_ce_n && flash_oe_n) && flash_oe_n)
        else $error("write strobe without select or with output enable");

    AST_NO_CONTENTION: assert property (@(posedge ref_clk) disable iff (srst)
        !flash_oe_n |-> !dq_oe)
        else $error("host drives data while device outputs");

    AST_WAKE: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(flash_reset_n) |-> (flash_ce_n && flash_oe_n) [*2])
        else $error("access too soon after reset release");
endmodule : fmc_host

// ---- core/fmc_pkg.sv ----
// Shared constants and types for the flash bus mode controller
package fmc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    // Bus timing, ns
    localparam int T_ACC_NS = 120;
    localparam int T_WE_PULSE_NS = 100;
    localparam int T_PROT_PULSE_NS = 10000;
    localparam int T_RESET_LOW_NS = 500;
    localparam int T_WAKE_NS = 50000;
    localparam int T_SLEEP_NS = 150;
    // Cycle counts, least times rounded up
    localparam int C_ACC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_WE_PULSE = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_PROT_PULSE = (T_PROT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RESET_LOW = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_WAKE = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_SLEEP = (T_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Address and data field positions, bus and timer widths (word mode)
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int A_ZERO_POS = 0;
    localparam int A_ONE_POS = 1;
    localparam int A_SIX_POS = 6;
    localparam int SECT_LO_POS = 12;
    localparam int PROT_FLAG_POS = 0;
    localparam int PARITY_POS = 7;
    localparam int TIMER_W = 16;
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_ID_READ,
        OP_PROT_VERIFY,
        OP_PROTECT,
        OP_RESET,
        OP_UNPROT_ON,
        OP_UNPROT_OFF
    } fmc_op_t;
endpackage : fmc_pkg

// ---- core/fmc_timer.sv ----
// Down counter timing one bus phase
`timescale 1ns/100ps
module fmc_timer #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    initial
    begin
        if (W < 2) $error("fmc_timer: W too small");
    end

    assign nxt_cnt = load ? value : ((cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff);
    // Phase lasts exactly the loaded number of cycles
    assign done = (cnt_ff == {{(W-1){1'b0}}, 1'b1});

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end
endmodule : fmc_timer

// ---- tb/fmc_flash_model.sv ----
// Behavioural flash device model seen from the controller's pins
`timescale 1ns/100ps
module fmc_flash_model
    import fmc_pkg::*;
#(
    parameter logic [DATA_W-1:0] MAKER_CODE = 16'h0001, // Arbitrary value
    parameter logic [DATA_W-1:0] PART_CODE = 16'h0013 // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic addr_bit_nine_hv,
    input wire logic oe_hv,
    input wire logic reset_hv,
    input wire logic [DATA_W-1:0] dq_o,
    input wire logic dq_oe,
    output logic [DATA_W-1:0] dq_i
);
    logic [DATA_W-1:0] mem [int];
    logic [127:0] prot_ff = '0;
    logic [DATA_W-1:0] last_ff = '0;
    logic [ADDR_W-1:0] wa = '0;
    logic [DATA_W-1:0] word;
    wire drive = flash_reset_n && !flash_ce_n && !flash_oe_n;
    wire verify = !flash_addr[6] && flash_addr[1:0] == 2'b10;
    always @*
    begin
        if (!addr_bit_nine_hv)
            word = mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 16'hFFFF;
        else if (verify)
            word = {15'h0000, prot_ff[flash_addr[18:12]]};
        else
            word = flash_addr[0] ? PART_CODE : MAKER_CODE;
    end
    // Device drives its word only when selected, output enabled and out of reset
    assign dq_i = dq_oe ? dq_o : drive ? word : ~last_ff;
    // Released bus toggles so stale values never look valid
    always @(posedge ref_clk)
        last_ff <= dq_i;
    always @(negedge flash_we_n)
        wa = flash_addr;
    always @(posedge flash_we_n)
    begin
        if (!flash_ce_n && flash_reset_n && addr_bit_nine_hv && oe_hv)
        begin
            // Address must not move during the pulse
            if (flash_addr == wa)
                prot_ff[wa[18:12]] = 1'b1;
        end
        else if (!flash_ce_n && flash_oe_n && flash_reset_n && dq_oe)
        begin
            if (!prot_ff[wa[18:12]] || reset_hv)
                mem[int'(wa)] = dq_o;
        end
    end
endmodule : fmc_flash_model

// ---- tb/testbench.sv ----
// Self-checking bench for the flash bus mode controller
`timescale 1ns/100ps
module testbench;
    import fmc_pkg::*;
    localparam logic [15:0] MAKER = 16'h0001;
    localparam logic [15:0] PART = 16'h0013;
    localparam int LIM = 2000;
    logic ref_clk = 0;
    logic srst = 1;
    logic cmd_valid = 0;
    fmc_op_t cmd_op = OP_READ;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_data = '0;
    wire cmd_ready, rsp_valid, rsp_parity_ok, rsp_protected, busy;
    wire [DATA_W-1:0] rsp_data, dq_o, dq_i;
    wire [ADDR_W-1:0] flash_addr;
    wire flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
    wire addr_bit_nine_hv, oe_hv, reset_hv, dq_oe;
    int bad_count = 0;
    int n_tests = 0;
    always #50 ref_clk = ~ref_clk;
    fmc_host #(.WAKE_CYCLES(4), .PROT_CYCLES(2)) fmc_host_inst (
        .ref_clk, .srst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready,
        .rsp_valid, .rsp_data, .rsp_parity_ok, .rsp_protected, .busy, .flash_addr,
        .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .addr_bit_nine_hv,
        .oe_hv, .reset_hv, .dq_o, .dq_oe, .dq_i
    );
    fmc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) fmc_flash_model_inst (
        .ref_clk, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
        .addr_bit_nine_hv, .oe_hv, .reset_hv, .dq_o, .dq_oe, .dq_i
    );
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // One command through the user port; returns in the response cycle, or right after the take for a reset
    task automatic op(input fmc_op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < LIM)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("ready_wait", n < LIM, 1);
        cmd_valid = 1;
        cmd_op = o;
        cmd_addr = a;
        cmd_data = d;
        @(negedge ref_clk);
        cmd_valid = 0;
        if (o == OP_READ)
            check("rd_strobes", {flash_ce_n, flash_oe_n, dq_oe}, 0);
        if (o == OP_WRITE)
            check("wr_strobes", {flash_ce_n, flash_oe_n, dq_oe}, 3'b011);
        if (o == OP_ID_READ)
            check("id_pins", {addr_bit_nine_hv, flash_addr[A_ONE_POS]}, 2'b10);
        if (o == OP_PROT_VERIFY)
            check("vfy", {addr_bit_nine_hv, flash_addr[A_SIX_POS], flash_addr[1:0]}, 4'b1010);
        if (o == OP_PROTECT)
        begin
            check("prot_hv", {oe_hv, addr_bit_nine_hv}, 2'b11);
            check("prot_sel", {flash_ce_n, flash_addr[A_SIX_POS]}, 2'b00);
        end
        // Second cycle after take is inside the write strobe pulse
        if (o == OP_WRITE || o == OP_PROTECT)
        begin
            @(negedge ref_clk);
            check("we_pulse", {flash_we_n, dq_o}, {1'b0, d});
        end
        if (o == OP_RESET)
            return;
        n = 0;
        while (rsp_valid !== 1'b1 && n < LIM)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("rsp_wait", n < LIM, 1);
        check("idle_pins", {flash_oe_n, dq_oe}, 2'b10);
    endtask : op
    initial
    begin
        #2000000;
        bad_count++;
        end_sim;
    end
    initial
    begin
        repeat (2) @(negedge ref_clk);
        check("rst_pin", flash_reset_n, 0);
        check("rst_dq_oe", dq_oe, 0);
        repeat (6) @(negedge ref_clk);
        srst = 0;
        repeat (3) @(negedge ref_clk);
        check("wake_ready", {flash_reset_n, cmd_ready}, 0);
        op(OP_READ, 19'h00010, 0);
        check("erased", rsp_data, 16'hFFFF);
        op(OP_WRITE, 19'h00003, 16'h1234);
        op(OP_WRITE, 19'h02004, 16'h5678);
        op(OP_READ, 19'h00003, 0);
        check("wr0", rsp_data, 16'h1234);
        op(OP_READ, 19'h02004, 0);
        check("wr1", rsp_data, 16'h5678);
        op(OP_ID_READ, 19'h7FFBC, 0);
        check("maker", rsp_data, MAKER);
        check("maker_par", rsp_parity_ok, 1);
        op(OP_ID_READ, 19'h55AB3, 0);
        check("part", rsp_data, PART);
        check("part_par", rsp_parity_ok, 1);
        op(OP_PROT_VERIFY, 19'h02000, 0);
        check("unprot", rsp_data, 0);
        op(OP_PROTECT, 19'h02040, 0);
        op(OP_PROT_VERIFY, 19'h02FFF, 0);
        check("prot_flag", rsp_protected, 1);
        check("prot_word", rsp_data, 1);
        op(OP_WRITE, 19'h02004, 16'h0F0F);
        op(OP_READ, 19'h02004, 0);
        check("blocked", rsp_data, 16'h5678);
        op(OP_UNPROT_ON, 0, 0);
        check("hv_on", reset_hv, 1);
        op(OP_WRITE, 19'h02004, 16'h0F0F);
        op(OP_UNPROT_OFF, 0, 0);
        check("hv_off", reset_hv, 0);
        op(OP_WRITE, 19'h02004, 16'hAAAA);
        op(OP_READ, 19'h02004, 0);
        check("unprot_wr", rsp_data, 16'h0F0F);
        op(OP_RESET, 0, 0);
        check("rst_op", {flash_reset_n, cmd_ready, busy}, 3'b001);
        op(OP_READ, 19'h00003, 0);
        check("after_rst", rsp_data, 16'h1234);
        end_sim;
    end
endmodule : testbench
